// ==== rfscb_pkg.sv ====
// shared constants of the rf receiver serial configuration bank
// Operation
// - reference-select low loads 16.368 MHz defaults, high loads 19.2 MHz defaults
// - rf enable pin low turns rf and pll off, high follows chip enable
// - chip enable low disables everything; high enables the device
// - chip enable rising edge reloads serial registers with pin-dependent defaults
// - four serial pins: clock, data in, chip select in; data out driven
// - every transfer is an address byte followed by one data byte
// - data out is released whenever active-low chip select is high
// - 12-bit feedback divider, high nibble then low byte, resets 96 or 1555
// - 6-bit reference divider in low bits, resets 1 or 19
// - three divider registers reach the 24-bit bus only on reference divider write
// - clock config bit 0 picks crystal or lo_div_96; default equals reference-select
// - clock config bit 1 enables slow slew, resets to 1
// - clock config bit 2 enables crystal clock out, resets 0 or 1
// - clock config bit 3 enables sample clock buffer, resets to 1
// - clock config upper nibble reserved, resets to 0100
// - master rf enable 0 leaves only oscillator and clock buffers running; here if buffer enable skips the master bit: if test bit 0 and chip enable
// - rf force on bit overrides rf enable pin; resets 0
// - two-bit charge pump code selects 50..200 uA, resets to 11
package rfscb_pkg;
	localparam int REG_COUNT = 8;
	localparam int SLOT_W = 3;
	localparam int BLOCK_W = 6;
	localparam int ADDR_RW_BIT = 7;
	localparam logic [4:0] BYTE_BITS = 5'h08;
	localparam logic [4:0] FRAME_BITS = 5'h10;

	// register offsets by slot, slot 0 in the low entry
	localparam logic [REG_COUNT-1:0][6:0] SLOT_OFFSET =
		{7'h60, 7'h52, 7'h51, 7'h50, 7'h43, 7'h42, 7'h41, 7'h40};
	localparam logic [SLOT_W-1:0] SLOT_FB_HIGH = 3'h0;
	localparam logic [SLOT_W-1:0] SLOT_FB_LOW = 3'h1;
	localparam logic [SLOT_W-1:0] SLOT_REF_DIV = 3'h2;
	localparam logic [SLOT_W-1:0] SLOT_CLK_CFG = 3'h3;
	localparam logic [SLOT_W-1:0] SLOT_IF_TEST = 3'h4;
	localparam logic [SLOT_W-1:0] SLOT_SUB_EN = 3'h5;
	localparam logic [SLOT_W-1:0] SLOT_TRIM = 3'h6;
	localparam logic [SLOT_W-1:0] SLOT_RF_OVR = 3'h7;

	// defaults: feedback 96 / 1555, reference 1 / 19, clock config 4a / 4f
	localparam logic [REG_COUNT-1:0][7:0] DEFAULT_MODE0 =
		{8'h33, 8'h1b, 8'hff, 8'h00, 8'h4a, 8'h01, 8'h60, 8'h00};
	localparam logic [REG_COUNT-1:0][7:0] DEFAULT_MODE1 =
		{8'h33, 8'h1b, 8'hff, 8'h00, 8'h4f, 8'h13, 8'h13, 8'h06};
	// writable bits; reserved and unused bits keep their default
	localparam logic [REG_COUNT-1:0][7:0] WRITE_MASK =
		{8'h80, 8'h1f, 8'hbf, 8'h01, 8'h0f, 8'h3f, 8'hff, 8'h0f};

	// field positions
	localparam int CLK_SRC_BIT = 0;
	localparam int SLOW_SLEW_BIT = 1;
	localparam int XTAL_OUT_BIT = 2;
	localparam int SMP_OUT_BIT = 3;
	localparam int IF_BUF_BIT = 0;
	localparam int MASTER_EN_BIT = 7;
	localparam int FORCE_ON_BIT = 7;
	localparam int CPI_LSB = 0;
	localparam int LFC_LSB = 2;
endpackage

// ==== rfscb_shift_if.sv ====
// carrier between the serial shifter and the register bank
`timescale 1ns/100ps
interface rfscb_shift_if;
	logic       port_enable;
	logic [7:0] addr;
	logic       wr_valid;
	logic [7:0] wr_data;
	logic [7:0] rd_data;

	modport shifter (input port_enable, input rd_data, output addr, output wr_valid,
		output wr_data);
	modport bank (output port_enable, output rd_data, input addr, input wr_valid,
		input wr_data);
endinterface

// ==== rfscb_shifter.sv ====
// serial port shifter: pin synchronisers, address and data byte framing
`timescale 1ns/100ps
module rfscb_shifter (
	input  wire logic           i_clk,
	input  wire logic           i_sys_rst,
	input  wire logic           i_spi_clk,
	input  wire logic           i_spi_cs_n,
	input  wire logic           i_serial_data_in_pin,
	output wire logic           o_spi_do,
	output wire logic           o_spi_do_oe,
	rfscb_shift_if.shifter      port
);
	typedef struct packed {
		logic [2:0] clk_pipe;
		logic [1:0] cs_n_pipe;
		logic [1:0] di_pipe;
		logic [4:0] bit_cnt;
		logic [7:0] in_sh;
		logic [7:0] out_sh;
		logic       load_rd;
		logic       oe;
		logic [7:0] addr;
		logic       wr_valid;
		logic [7:0] wr_data;
	} rfscb_shift_state_t;

	rfscb_shift_state_t s_reg;
	rfscb_shift_state_t s_next;
	logic               rise;
	logic               fall;
	logic               selected;
	logic [7:0]         in_byte;

	// pins pass two flops; edges are taken between the second and third clock stage
	always_comb begin
		s_next = s_reg;
		s_next.clk_pipe = {s_reg.clk_pipe[1:0], i_spi_clk};
		s_next.cs_n_pipe = {s_reg.cs_n_pipe[0], i_spi_cs_n};
		s_next.di_pipe = {s_reg.di_pipe[0], i_serial_data_in_pin};
		rise = s_reg.clk_pipe[1] & ~s_reg.clk_pipe[2];
		fall = ~s_reg.clk_pipe[1] & s_reg.clk_pipe[2];
		selected = ~s_reg.cs_n_pipe[1] & port.port_enable;
		in_byte = {s_reg.in_sh[6:0], s_reg.di_pipe[1]};
		s_next.wr_valid = 1'b0;
		s_next.load_rd = 1'b0;
		s_next.oe = selected;
		if (!selected) begin
			s_next.bit_cnt = 5'h00;
		end else begin
			// msb first on rising edges, extra bits past the frame are ignored
			if (rise && s_reg.bit_cnt != rfscb_pkg::FRAME_BITS) begin
				s_next.in_sh = in_byte;
				s_next.bit_cnt = s_reg.bit_cnt + 5'h01;
				if (s_reg.bit_cnt == rfscb_pkg::BYTE_BITS - 5'h01) begin
					s_next.addr = in_byte;
					s_next.load_rd = in_byte[rfscb_pkg::ADDR_RW_BIT];
				end
				if (s_reg.bit_cnt == rfscb_pkg::FRAME_BITS - 5'h01
						&& !s_reg.addr[rfscb_pkg::ADDR_RW_BIT]) begin
					s_next.wr_data = in_byte;
					s_next.wr_valid = 1'b1;
				end
			end
			// first read bit waits out the eighth falling edge
			if (fall && s_reg.bit_cnt > rfscb_pkg::BYTE_BITS) begin
				s_next.out_sh = {s_reg.out_sh[6:0], 1'b0};
			end
		end
		// selected register goes onto data out
		if (s_reg.load_rd) begin
			s_next.out_sh = port.rd_data;
		end
	end

	// state register
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			s_reg <= '0;
			// chip select idles high; a cleared synchroniser would fake a selection
			s_reg.cs_n_pipe <= '1;
		end else begin
			s_reg <= s_next;
		end
	end

	// data out is the only serial pin driven here
	assign o_spi_do = s_reg.out_sh[7];
	assign o_spi_do_oe = s_reg.oe;
	assign port.addr = s_reg.addr;
	assign port.wr_valid = s_reg.wr_valid;
	assign port.wr_data = s_reg.wr_data;
endmodule

// ==== rfscb_bank.sv ====
// top of the configuration bank: registers, defaults, divider commit, enables
`timescale 1ns/100ps
module rfscb_bank (
	input  wire logic                           i_clk,
	input  wire logic                           i_sys_rst,
	input  wire logic                           i_chip_enable_pin,
	input  wire logic                           i_rf_chain_enable_pin,
	input  wire logic                           i_ref_select_pin,
	input  wire logic                           i_spi_clk,
	input  wire logic                           i_spi_cs_n,
	input  wire logic                           i_serial_data_in_pin,
	output wire logic                           o_spi_do,
	output wire logic                           o_spi_do_oe,
	output wire logic                           o_chip_enabled,
	output wire logic                           o_rf_chain_on,
	output wire logic [23:0]                    o_divider_bus,
	output wire logic                           o_sample_clock_source_sel,
	output wire logic                           o_slow_slew_enable,
	output wire logic                           o_crystal_clock_out_enable,
	output wire logic                           o_sample_clock_out_enable,
	output wire logic                           o_if_buffer_enable,
	output wire logic [rfscb_pkg::BLOCK_W-1:0]  o_block_enable,
	output wire logic [1:0]                     o_charge_pump_current_sel,
	output wire logic [2:0]                     o_loop_filter_ctrl
);
	typedef struct packed {
		logic [1:0]                                ce_pipe;
		logic                                      ce_prev;
		logic [1:0]                                mode_pipe;
		logic [1:0]                                rfen_pipe;
		logic [rfscb_pkg::REG_COUNT-1:0][7:0]      bank;
		logic [23:0]                               div_bus;
		logic                                      chip_on;
		logic                                      rf_on;
		logic [rfscb_pkg::BLOCK_W-1:0]             blocks;
		logic                                      clk_src;
		logic                                      slow_slew;
		logic                                      xtal_out;
		logic                                      smp_out;
		logic                                      if_buf;
		logic [1:0]                                charge_pump_current_sel;
		logic [2:0]                                lfc;
	} rfscb_bank_state_t;

	rfscb_bank_state_t                  s_reg;
	rfscb_bank_state_t                  s_next;
	logic [rfscb_pkg::REG_COUNT-1:0]    hit;
	logic                               ce_rise;
	logic [rfscb_pkg::REG_COUNT-1:0][7:0] dflt;
	logic [7:0]                         rd_byte;
	logic [7:0]                         sub_en;
	logic [7:0]                         clk_cfg;
	logic [7:0]                         trim;

	rfscb_shift_if port ();

	// serial framing lives in its own module so the bank sees whole bytes only
	rfscb_shifter u_shifter (
		.i_clk       (i_clk),
		.i_sys_rst   (i_sys_rst),
		.i_spi_clk   (i_spi_clk),
		.i_spi_cs_n  (i_spi_cs_n),
		.i_serial_data_in_pin    (i_serial_data_in_pin),
		.o_spi_do    (o_spi_do),
		.o_spi_do_oe (o_spi_do_oe),
		.port        (port.shifter)
	);

	// one address comparator per register entry
	genvar gi;
	generate
		for (gi = 0; gi < rfscb_pkg::REG_COUNT; gi++) begin : g_decode
			// low seven bits pick the register
			assign hit[gi] = (port.addr[6:0] == rfscb_pkg::SLOT_OFFSET[gi]);
		end
	endgenerate

	// readback: unmapped addresses answer zero
	always_comb begin
		rd_byte = 8'h00;
		for (int i = 0; i < rfscb_pkg::REG_COUNT; i++) begin
			if (hit[i]) begin
				rd_byte = s_reg.bank[i];
			end
		end
	end

	assign port.rd_data = rd_byte;
	assign port.port_enable = s_reg.chip_on;

	// current field sources, read from the committed register copy
	assign sub_en = s_reg.bank[rfscb_pkg::SLOT_SUB_EN];
	assign clk_cfg = s_reg.bank[rfscb_pkg::SLOT_CLK_CFG];
	assign trim = s_reg.bank[rfscb_pkg::SLOT_TRIM];

	// next state of the whole bank
	always_comb begin
		s_next = s_reg;
		// pins are asynchronous: two flops each before anything reads them
		s_next.ce_pipe = {s_reg.ce_pipe[0], i_chip_enable_pin};
		s_next.ce_prev = s_reg.ce_pipe[1];
		s_next.mode_pipe = {s_reg.mode_pipe[0], i_ref_select_pin};
		s_next.rfen_pipe = {s_reg.rfen_pipe[0], i_rf_chain_enable_pin};
		ce_rise = s_reg.ce_pipe[1] & ~s_reg.ce_prev;

		// default table follows the reference-select pin
		dflt = s_reg.mode_pipe[1] ? rfscb_pkg::DEFAULT_MODE1 : rfscb_pkg::DEFAULT_MODE0;

		// register writes through the per-register mask
		if (port.wr_valid) begin
			for (int i = 0; i < rfscb_pkg::REG_COUNT; i++) begin
				if (hit[i]) begin
					s_next.bank[i] = (s_reg.bank[i] & ~rfscb_pkg::WRITE_MASK[i])
						| (port.wr_data & rfscb_pkg::WRITE_MASK[i]);
				end
			end
			// staged dividers move to the bus together on reference write
			if (hit[rfscb_pkg::SLOT_REF_DIV]) begin
				s_next.div_bus = {s_next.bank[rfscb_pkg::SLOT_FB_HIGH],
					s_next.bank[rfscb_pkg::SLOT_FB_LOW],
					s_next.bank[rfscb_pkg::SLOT_REF_DIV]};
			end
		end

		// defaults on the chip enable edge; held there while disabled
		// reloading while low means the mode pin is caught by clocked logic, never by reset
		if (!s_reg.ce_pipe[1] || ce_rise) begin
			s_next.bank = dflt;
			s_next.div_bus = {dflt[rfscb_pkg::SLOT_FB_HIGH], dflt[rfscb_pkg::SLOT_FB_LOW],
				dflt[rfscb_pkg::SLOT_REF_DIV]};
		end

		s_next.chip_on = s_reg.ce_pipe[1];

		// rf chain gating: pin or override, master bit, chip enable
		s_next.rf_on = s_reg.ce_pipe[1] & sub_en[rfscb_pkg::MASTER_EN_BIT]
			& (s_reg.rfen_pipe[1]
			| s_reg.bank[rfscb_pkg::SLOT_RF_OVR][rfscb_pkg::FORCE_ON_BIT]);
		s_next.blocks = sub_en[rfscb_pkg::BLOCK_W-1:0] & {rfscb_pkg::BLOCK_W{s_next.rf_on}};

		s_next.clk_src = clk_cfg[rfscb_pkg::CLK_SRC_BIT];
		s_next.slow_slew = clk_cfg[rfscb_pkg::SLOW_SLEW_BIT];
		// clock buffers survive master disable, not chip disable
		s_next.xtal_out = clk_cfg[rfscb_pkg::XTAL_OUT_BIT] & s_reg.ce_pipe[1];
		s_next.smp_out = clk_cfg[rfscb_pkg::SMP_OUT_BIT] & s_reg.ce_pipe[1];
		s_next.if_buf = s_reg.bank[rfscb_pkg::SLOT_IF_TEST][rfscb_pkg::IF_BUF_BIT]
			& s_reg.ce_pipe[1];
		// charge pump code, 00 lowest current
		s_next.charge_pump_current_sel = trim[rfscb_pkg::CPI_LSB +: 2];
		s_next.lfc = trim[rfscb_pkg::LFC_LSB +: 3];
	end

	// state register; reset takes the low-reference table as a constant
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			s_reg <= '0;
			s_reg.bank <= rfscb_pkg::DEFAULT_MODE0;
			s_reg.div_bus <= {rfscb_pkg::DEFAULT_MODE0[rfscb_pkg::SLOT_FB_HIGH],
				rfscb_pkg::DEFAULT_MODE0[rfscb_pkg::SLOT_FB_LOW],
				rfscb_pkg::DEFAULT_MODE0[rfscb_pkg::SLOT_REF_DIV]};
		end else begin
			s_reg <= s_next;
		end
	end

	// all outputs straight from flops
	assign o_chip_enabled = s_reg.chip_on;
	assign o_rf_chain_on = s_reg.rf_on;
	assign o_divider_bus = s_reg.div_bus;
	assign o_sample_clock_source_sel = s_reg.clk_src;
	assign o_slow_slew_enable = s_reg.slow_slew;
	assign o_crystal_clock_out_enable = s_reg.xtal_out;
	assign o_sample_clock_out_enable = s_reg.smp_out;
	assign o_if_buffer_enable = s_reg.if_buf;
	assign o_block_enable = s_reg.blocks;
	assign o_charge_pump_current_sel = s_reg.charge_pump_current_sel;
	assign o_loop_filter_ctrl = s_reg.lfc;
endmodule

// ==== rfscb_bank_sva.sv ====
// assertion checker watching the configuration bank ports
`timescale 1ns/100ps
module rfscb_bank_sva (
	input  wire logic                          i_clk,
	input  wire logic                          i_sys_rst,
	input  wire logic                          i_chip_enable_pin,
	input  wire logic                          i_spi_cs_n,
	input  wire logic                          o_spi_do_oe,
	input  wire logic                          o_chip_enabled,
	input  wire logic                          o_rf_chain_on,
	input  wire logic [23:0]                   o_divider_bus,
	input  wire logic                          o_crystal_clock_out_enable,
	input  wire logic                          o_sample_clock_out_enable,
	input  wire logic                          o_if_buffer_enable,
	input  wire logic [rfscb_pkg::BLOCK_W-1:0] o_block_enable
);
	// single domain, so clock and reset are stated once
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);

	// synchroniser plus register is three cycles, so four cycles of cs_n high must release
	AST_DO_RELEASE: assert property (i_spi_cs_n [*4] |-> !o_spi_do_oe)
		else $error("data out still driven with chip select high");
	AST_DO_DRIVE: assert property ($fell(i_spi_cs_n) && o_chip_enabled |-> ##[1:5] o_spi_do_oe)
		else $error("data out not driven inside a frame");
	AST_CHIP_OFF: assert property (!i_chip_enable_pin [*4] |-> !o_chip_enabled)
		else $error("chip reported enabled with pin low");
	AST_RF_OFF: assert property (!o_chip_enabled [*3] |-> !o_rf_chain_on && o_block_enable == '0)
		else $error("rf chain on while chip disabled");
	AST_BUFS_OFF: assert property (!o_chip_enabled [*3] |-> !o_crystal_clock_out_enable
		&& !o_sample_clock_out_enable && !o_if_buffer_enable)
		else $error("buffer enabled while chip disabled");
	AST_OE_OFF: assert property (!o_chip_enabled [*3] |-> !o_spi_do_oe)
		else $error("serial port alive while chip disabled");
	AST_DIV_FIELDS: assert property (o_divider_bus[23:20] == 4'h0 && o_divider_bus[7:6] == 2'h0)
		else $error("unused divider bus bits set");
	// bus may only move when a frame or an enable edge gives it cause
	AST_DIV_HOLD: assert property ((i_spi_cs_n && o_chip_enabled) [*8] |-> $stable(o_divider_bus))
		else $error("divider bus changed without a write");
	AST_DIV_RESET: assert property ($fell(i_sys_rst) |-> o_divider_bus == 24'h006001)
		else $error("divider bus reset value wrong");

	// main scenarios reached
	COV_READ: cover property ($rose(o_spi_do_oe));
	COV_RF_ON: cover property ($rose(o_rf_chain_on));
	COV_DIV: cover property ($changed(o_divider_bus) && o_chip_enabled);
endmodule

bind rfscb_bank rfscb_bank_sva rfscb_bank_sva_i (.i_clk, .i_sys_rst, .i_chip_enable_pin,
	.i_spi_cs_n, .o_spi_do_oe, .o_chip_enabled, .o_rf_chain_on, .o_divider_bus,
	.o_crystal_clock_out_enable, .o_sample_clock_out_enable, .o_if_buffer_enable,
	.o_block_enable);

// ==== rfscb_host_model.sv ====
// serial master model standing in for the baseband processor
`timescale 1ns/100ps
module rfscb_host_model (
	input  wire logic i_clk,
	input  wire logic i_spi_do,
	input  wire logic i_spi_do_oe,
	output logic      o_spi_clk,
	output logic      o_spi_cs_n,
	output logic      o_serial_data_in_pin
);
	initial begin
		o_spi_clk = 1'b0;
		o_spi_cs_n = 1'b1;
		o_serial_data_in_pin = 1'b0;
	end

	// address then data, msb first
	// half periods of five cycles leave margin over the three-cycle minimum
	task automatic xfer(input logic [15:0] w, input int n, output logic [7:0] q);
		q = 8'h00;
		o_spi_cs_n <= 1'b0;
		repeat (4) @(posedge i_clk);
		for (int i = 0; i < n; i++) begin
			o_serial_data_in_pin <= w[15-i];
			repeat (5) @(posedge i_clk);
			// a released line reads as the inverse of the previous bit, never as a stuck level
			q = {q[6:0], i_spi_do_oe ? i_spi_do : ~q[0]};
			o_spi_clk <= 1'b1;
			repeat (5) @(posedge i_clk);
			o_spi_clk <= 1'b0;
		end
		repeat (5) @(posedge i_clk);
		o_spi_cs_n <= 1'b1;
		o_serial_data_in_pin <= ~o_serial_data_in_pin;
		repeat (6) @(posedge i_clk);
	endtask
endmodule

// ==== rf_receiver_spi_config_bank_tb.sv ====
// self-checking testbench of the configuration bank
`timescale 1ns/100ps
module rf_receiver_spi_config_bank_tb;
	logic                          i_clk = 1'b0;
	logic                          i_sys_rst = 1'b1;
	logic                          ce = 1'b0;
	logic                          rf = 1'b0;
	logic                          refsel = 1'b0;
	wire logic                     sclk, csn, di, sdo, oe, chip_on, rf_on;
	wire logic                     src, slew, xo, so, if_buffer_test;
	wire logic [23:0]              div;
	wire logic [rfscb_pkg::BLOCK_W-1:0] blk;
	wire logic [1:0]               charge_pump_current_sel;
	wire logic [2:0]               lfc;
	int                            error_cnt = 0;
	int                            num_checks = 0;
	logic [7:0]                    q;
	logic [7:0]                    offs [8] = '{8'h40, 8'h41, 8'h42, 8'h43, 8'h50, 8'h51, 8'h52, 8'h60};

	always #2.5 i_clk = ~i_clk;

	rfscb_bank rfscb_bank_i (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_chip_enable_pin(ce),
		.i_rf_chain_enable_pin(rf), .i_ref_select_pin(refsel), .i_spi_clk(sclk),
		.i_spi_cs_n(csn), .i_serial_data_in_pin(di), .o_spi_do(sdo), .o_spi_do_oe(oe),
		.o_chip_enabled(chip_on), .o_rf_chain_on(rf_on), .o_divider_bus(div),
		.o_sample_clock_source_sel(src), .o_slow_slew_enable(slew),
		.o_crystal_clock_out_enable(xo), .o_sample_clock_out_enable(so),
		.o_if_buffer_enable(if_buffer_test), .o_block_enable(blk), .o_charge_pump_current_sel(charge_pump_current_sel),
		.o_loop_filter_ctrl(lfc));
	rfscb_host_model rfscb_host_model_i (.i_clk(i_clk), .i_spi_do(sdo), .i_spi_do_oe(oe),
		.o_spi_clk(sclk), .o_spi_cs_n(csn), .o_serial_data_in_pin(di));

	task automatic check(input string n, input logic [23:0] e, input logic [23:0] g);
		num_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic results;
		if (error_cnt == 0 && num_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		rfscb_host_model_i.xfer({a, d}, 16, q);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		rfscb_host_model_i.xfer({a | 8'h80, 8'h00}, 16, q);
		check("read", e, q);
	endtask
	// factory test pins are tied outside this bank, so the bench has none to drive
	// pins change at an edge; six cycles covers synchronisers and the reload
	task automatic pins(input logic c, input logic r, input logic m);
		@(posedge i_clk);
		ce <= c;
		rf <= r;
		refsel <= m;
		repeat (6) @(posedge i_clk);
	endtask

	// defaults reloaded by the chip enable rising edge, per reference mode
	task automatic t_defaults(input logic m);
		logic [7:0] e [8];
		if (m) begin
			e = '{8'h06, 8'h13, 8'h13, 8'h4f, 8'h00, 8'hff, 8'h1b, 8'h33};
		end else begin
			e = '{8'h00, 8'h60, 8'h01, 8'h4a, 8'h00, 8'hff, 8'h1b, 8'h33};
		end
		pins(1'b0, 1'b1, m);
		pins(1'b1, 1'b1, m);
		for (int i = 0; i < 8; i++) rd(offs[i], e[i]);
		check("divider bus", {e[0], e[1], e[2]}, div);
		check("clock outputs", {m, 1'b1, m, 1'b1}, {src, slew, xo, so});
	endtask
	// staged feedback divider reaches the bus only with the reference divider
	task automatic t_divider;
		wr(8'h40, 8'hff);
		wr(8'h41, 8'hab);
		check("staged bus", 24'h006001, div);
		wr(8'h42, 8'hff);
		check("committed bus", 24'h0fab3f, div);
		rd(8'h40, 8'h0f);
		rd(8'h42, 8'h3f);
	endtask
	// reserved nibble keeps 0100 while every field is flipped
	task automatic t_clkcfg;
		wr(8'h43, 8'hf0);
		rd(8'h43, 8'h40);
		check("clock outputs off", 4'h0, {src, slew, xo, so});
		wr(8'h43, 8'h0f);
		rd(8'h43, 8'h4f);
		check("clock outputs on", 4'hf, {src, slew, xo, so});
	endtask
	// rf pin, override and master enable against the chain outputs
	task automatic t_rf;
		pins(1'b1, 1'b0, 1'b0);
		check("rf pin low", 7'h00, {rf_on, blk});
		pins(1'b1, 1'b1, 1'b0);
		check("rf pin high", 7'h7f, {rf_on, blk});
		wr(8'h50, 8'hff);
		rd(8'h50, 8'h01);
		check("if buffer", 1'b1, if_buffer_test);
		pins(1'b1, 1'b0, 1'b0);
		wr(8'h60, 8'hff);
		rd(8'h60, 8'hb3);
		check("forced on", 7'h7f, {rf_on, blk});
		wr(8'h51, 8'h3f);
		check("master off", 7'h00, {rf_on, blk});
		for (int i = 0; i < 4; i++) begin
			wr(8'h52, 8'(i));
			check("charge pump", 5'(i), {lfc, charge_pump_current_sel});
		end
	endtask
	// unmapped read, cut frame, and chip disable
	task automatic t_misc;
		rd(8'h55, 8'h00);
		rfscb_host_model_i.xfer({8'h43, 8'h00}, 12, q);
		rd(8'h43, 8'h4f);
		pins(1'b0, 1'b1, 1'b0);
		check("disabled", 4'h0, {chip_on, oe, if_buffer_test, xo});
	endtask

	initial begin
		repeat (2) @(posedge i_clk);
		i_sys_rst <= 1'b0;
		t_defaults(1'b0);
		t_divider;
		t_clkcfg;
		t_rf;
		t_misc;
		t_defaults(1'b1);
		results;
	end

	// guard against a hung run
	initial begin
		repeat (40000) @(posedge i_clk);
		error_cnt++;
		results;
	end
endmodule
